// >>> rtl/bce_branch_condition_evaluator.sv
`timescale 1ns/1ps
`include "bce_defs.svh"
module bce_branch_condition_evaluator (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic opcode_valid,
	input wire logic [7:0] opcode,
	input wire logic flag_carry,
	input wire logic flag_zero,
	input wire logic flag_sign,
	input wire logic flag_wrap,
	output logic is_short_branch,
	output logic is_absolute_branch,
	output logic [3:0] condition_selector,
	output logic branch_taken,
	output logic branch_not_taken,
	output bce_pkg::bce_ctl_t ctl_op,
	output logic result_valid
);
	// Opcode field extraction
	logic [3:0] sel_field;
	logic [3:0] low_field;
	logic is_jump;
	logic cond_true;
	// Output stage state
	bce_pkg::bce_state_t state_reg;
	bce_pkg::bce_state_t state_next;
	// Decode of the single-byte column, used only for valid opcodes
	function automatic bce_pkg::bce_ctl_t bce_ctl_decode(input logic [7:0] op);
		begin
			case (op)
				`BCE_OP_IDLE: bce_ctl_decode = bce_pkg::BCE_CTL_IDLE;
				`BCE_OP_STOP: bce_ctl_decode = bce_pkg::BCE_CTL_STOP;
				`BCE_OP_IRQ_MASK: bce_ctl_decode = bce_pkg::BCE_CTL_IRQ_MASK_ALL;
				`BCE_OP_IRQ_UNMASK: bce_ctl_decode = bce_pkg::BCE_CTL_IRQ_UNMASK_ALL;
				`BCE_OP_CALL_EXIT: bce_ctl_decode = bce_pkg::BCE_CTL_CALL_EXIT;
				`BCE_OP_INT_EXIT: bce_ctl_decode = bce_pkg::BCE_CTL_INTERRUPT_EXIT;
				`BCE_OP_CARRY_ZERO: bce_ctl_decode = bce_pkg::BCE_CTL_CARRY_ZEROIZE;
				`BCE_OP_CARRY_ONE: bce_ctl_decode = bce_pkg::BCE_CTL_CARRY_FORCE_ONE;
				`BCE_OP_CARRY_INV: bce_ctl_decode = bce_pkg::BCE_CTL_CARRY_INVERT;
				`BCE_OP_NOP: bce_ctl_decode = bce_pkg::BCE_CTL_NOP;
				default: bce_ctl_decode = bce_pkg::BCE_CTL_NONE;
			endcase
		end
	endfunction
	assign sel_field = opcode[`BCE_SEL_HI:`BCE_SEL_LO];
	assign low_field = opcode[`BCE_LOW_HI:`BCE_LOW_LO];
	// Conditional jumps are the xB and xD columns
	assign is_jump = (low_field == `BCE_LOW_SHORT_BRANCH) || (low_field == `BCE_LOW_ABS_BRANCH);
	// Flag-only condition evaluation
	bce_cond_eval u_eval (
		.condition_selector(sel_field),
		.carry(flag_carry),
		.zero(flag_zero),
		.sign(flag_sign),
		.wrap(flag_wrap),
		.cond_true(cond_true)
	);
	// Leave reset state after first clock
	always_comb
	begin
		case (state_reg)
			bce_pkg::BCE_ST_RESET: state_next = bce_pkg::BCE_ST_RUN;
			bce_pkg::BCE_ST_RUN: state_next = bce_pkg::BCE_ST_RUN;
			default: state_next = bce_pkg::BCE_ST_RESET;
		endcase
	end
	// State register
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			state_reg <= bce_pkg::BCE_ST_RESET;
		else
			state_reg <= state_next;
	end
	// Registered valid strobe, one cycle after request
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			result_valid <= 1'b0;
		else
			result_valid <= opcode_valid;
	end
	// Jump kind and selector outputs
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			is_short_branch <= 1'b0;
			is_absolute_branch <= 1'b0;
			condition_selector <= `BCE_COND_NEVER;
		end
		else
		begin
			is_short_branch <= opcode_valid && (low_field == `BCE_LOW_SHORT_BRANCH);
			is_absolute_branch <= opcode_valid && (low_field == `BCE_LOW_ABS_BRANCH);
			condition_selector <= opcode_valid ? sel_field : `BCE_COND_NEVER;
		end
	end
	// Taken / not-taken decision
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			branch_taken <= 1'b0;
			branch_not_taken <= 1'b0;
		end
		else
		begin
			branch_taken <= opcode_valid && is_jump && cond_true;
			branch_not_taken <= opcode_valid && is_jump && !cond_true;
		end
	end
	// Single-byte control opcode output
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			ctl_op <= bce_pkg::BCE_CTL_NONE;
		else if (opcode_valid)
			ctl_op <= bce_ctl_decode(opcode);
		else
			ctl_op <= bce_pkg::BCE_CTL_NONE;
	end
	taken_rule_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		opcode_valid |=> (branch_taken == ($past(is_jump) && $past(cond_true))))
		else $error("taken mismatch");
	outcome_onehot_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump) |=> (branch_taken ^ branch_not_taken))
		else $error("jump outcome not one-hot");
	selector_pass_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		opcode_valid |=> condition_selector == $past(sel_field))
		else $error("selector not passed");
	abs_kind_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && low_field == `BCE_LOW_ABS_BRANCH) |=> is_absolute_branch)
		else $error("absolute jump kind missed");
	never_taken_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_NEVER) |=> !branch_taken)
		else $error("never selector taken");
	always_taken_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_ALWAYS) |=> branch_taken)
		else $error("always selector not taken");
	carry_test_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_CARRY_SET) |=>
		branch_taken == $past(flag_carry))
		else $error("carry selector wrong");
	zero_test_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_ZERO_SET) |=>
		branch_taken == $past(flag_zero))
		else $error("zero selector wrong");
	carry_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_CARRY_CLEAR) |=>
		branch_taken == !$past(flag_carry))
		else $error("carry clear selector wrong");
	sign_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_SIGN_CLEAR) |=>
		branch_taken == !$past(flag_sign))
		else $error("sign clear selector wrong");
	wrap_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_WRAP_SET) |=>
		branch_taken == $past(flag_wrap))
		else $error("overflow selector wrong");
	signed_least_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_SIGNED_AT_LEAST) |=>
		branch_taken == !($past(flag_sign) ^ $past(flag_wrap)))
		else $error("signed at-least wrong");
	signed_below_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_SIGNED_BELOW) |=>
		branch_taken == ($past(flag_sign) ^ $past(flag_wrap)))
		else $error("signed below wrong");
	signed_above_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_SIGNED_ABOVE) |=>
		branch_taken == !($past(flag_zero) | ($past(flag_sign) ^ $past(flag_wrap))))
		else $error("signed above wrong");
	signed_most_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_SIGNED_AT_MOST) |=>
		branch_taken == ($past(flag_zero) | ($past(flag_sign) ^ $past(flag_wrap))))
		else $error("signed at-most wrong");
	unsigned_above_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_UNSIGNED_ABOVE) |=>
		branch_taken == (!$past(flag_carry) && !$past(flag_zero)))
		else $error("unsigned above wrong");
	unsigned_most_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && is_jump && sel_field == `BCE_COND_UNSIGNED_AT_MOST) |=>
		branch_taken == ($past(flag_carry) || $past(flag_zero)))
		else $error("unsigned at-most wrong");
	stop_decode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && opcode == `BCE_OP_STOP) |=> ctl_op == bce_pkg::BCE_CTL_STOP)
		else $error("stop opcode not decoded");
	nop_decode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(opcode_valid && opcode == `BCE_OP_NOP) |=> ctl_op == bce_pkg::BCE_CTL_NOP)
		else $error("no-operation opcode not decoded");
	// Idle request clears result_valid, branch_taken and ctl_op
	idle_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!opcode_valid |=> !result_valid && !branch_taken && ctl_op == bce_pkg::BCE_CTL_NONE)
		else $error("outputs active without request");
	// Reset state left after one clock
	run_state_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_reg == bce_pkg::BCE_ST_RESET |=> state_reg == bce_pkg::BCE_ST_RUN)
		else $error("output stage stuck in reset state");
	// Main scenarios
	taken_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) branch_taken);
	not_taken_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) branch_not_taken);
	ctl_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
		ctl_op == bce_pkg::BCE_CTL_CARRY_INVERT);
	back_to_back_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
		branch_taken ##1 branch_not_taken);
endmodule // bce_branch_condition_evaluator

// >>> rtl/bce_cond_eval.sv
`timescale 1ns/1ps
`include "bce_defs.svh"
// Pure condition evaluation from the four flags
module bce_cond_eval (
	input wire logic [3:0] condition_selector,
	input wire logic carry,
	input wire logic zero,
	input wire logic sign,
	input wire logic wrap,
	output logic cond_true
);
	// Signed less-than term
	logic sv_diff;
	assign sv_diff = sign ^ wrap;
	// Selector table
	always_comb
	begin
		case (condition_selector)
			`BCE_COND_NEVER: cond_true = 1'b0;
			`BCE_COND_ALWAYS: cond_true = 1'b1;
			`BCE_COND_CARRY_SET: cond_true = carry;
			`BCE_COND_CARRY_CLEAR: cond_true = ~carry;
			`BCE_COND_ZERO_SET: cond_true = zero;
			`BCE_COND_ZERO_CLEAR: cond_true = ~zero;
			`BCE_COND_SIGN_CLEAR: cond_true = ~sign;
			`BCE_COND_SIGN_SET: cond_true = sign;
			`BCE_COND_WRAP_SET: cond_true = wrap;
			`BCE_COND_WRAP_CLEAR: cond_true = ~wrap;
			`BCE_COND_SIGNED_AT_LEAST: cond_true = ~sv_diff;
			`BCE_COND_SIGNED_BELOW: cond_true = sv_diff;
			`BCE_COND_SIGNED_ABOVE: cond_true = ~(zero | sv_diff);
			`BCE_COND_SIGNED_AT_MOST: cond_true = zero | sv_diff;
			`BCE_COND_UNSIGNED_ABOVE: cond_true = ~carry & ~zero;
			`BCE_COND_UNSIGNED_AT_MOST: cond_true = carry | zero;
			default: cond_true = 1'b0;
		endcase
	end
endmodule // bce_cond_eval

// >>> rtl/bce_defs.svh
`ifndef BCE_DEFS_SVH
`define BCE_DEFS_SVH
// Condition selector codes
`define BCE_COND_NEVER 4'h0
`define BCE_COND_SIGNED_BELOW 4'h1
`define BCE_COND_SIGNED_AT_MOST 4'h2
`define BCE_COND_UNSIGNED_AT_MOST 4'h3
`define BCE_COND_WRAP_SET 4'h4
`define BCE_COND_SIGN_SET 4'h5
`define BCE_COND_ZERO_SET 4'h6
`define BCE_COND_CARRY_SET 4'h7
`define BCE_COND_ALWAYS 4'h8
`define BCE_COND_SIGNED_AT_LEAST 4'h9
`define BCE_COND_SIGNED_ABOVE 4'hA
`define BCE_COND_UNSIGNED_ABOVE 4'hB
`define BCE_COND_WRAP_CLEAR 4'hC
`define BCE_COND_SIGN_CLEAR 4'hD
`define BCE_COND_ZERO_CLEAR 4'hE
`define BCE_COND_CARRY_CLEAR 4'hF
// Opcode field layout
`define BCE_SEL_HI 7
`define BCE_SEL_LO 4
`define BCE_LOW_HI 3
`define BCE_LOW_LO 0
// Low nibbles of conditional jumps and single-byte column
`define BCE_LOW_SHORT_BRANCH 4'hB
`define BCE_LOW_ABS_BRANCH 4'hD
`define BCE_LOW_SINGLE 4'hF
// Single-byte opcodes
`define BCE_OP_IDLE 8'h6F
`define BCE_OP_STOP 8'h7F
`define BCE_OP_IRQ_MASK 8'h8F
`define BCE_OP_IRQ_UNMASK 8'h9F
`define BCE_OP_CALL_EXIT 8'hAF
`define BCE_OP_INT_EXIT 8'hBF
`define BCE_OP_CARRY_ZERO 8'hCF
`define BCE_OP_CARRY_ONE 8'hDF
`define BCE_OP_CARRY_INV 8'hEF
`define BCE_OP_NOP 8'hFF
`endif

// >>> rtl/bce_pkg.sv
package bce_pkg;
	// Single-byte control operations
	typedef enum logic [3:0] {
		BCE_CTL_NONE = 4'h0,
		BCE_CTL_IDLE = 4'h1,
		BCE_CTL_STOP = 4'h2,
		BCE_CTL_IRQ_MASK_ALL = 4'h3,
		BCE_CTL_IRQ_UNMASK_ALL = 4'h4,
		BCE_CTL_CALL_EXIT = 4'h5,
		BCE_CTL_INTERRUPT_EXIT = 4'h6,
		BCE_CTL_CARRY_ZEROIZE = 4'h7,
		BCE_CTL_CARRY_FORCE_ONE = 4'h8,
		BCE_CTL_CARRY_INVERT = 4'h9,
		BCE_CTL_NOP = 4'hA
	} bce_ctl_t;
	// Output stage state, Gray coded
	typedef enum logic [1:0] {
		BCE_ST_RESET = 2'b00,
		BCE_ST_RUN = 2'b01
	} bce_state_t;
endpackage

// >>> tb/bce_branch_condition_evaluator_tb.sv
`timescale 1ns/1ps
`include "bce_defs.svh"
module bce_branch_condition_evaluator_tb;
	logic ref_clk; // Core clock
	logic sys_rst; // Synchronous reset
	logic opcode_valid, flag_carry, flag_zero, flag_sign, flag_wrap; // Model outputs
	logic [7:0] opcode; // Fetched byte
	logic is_short_branch, is_absolute_branch, branch_taken, branch_not_taken, result_valid;
	logic [3:0] condition_selector; // Registered selector
	bce_pkg::bce_ctl_t ctl_op; // Control decode
	int mismatches;
	int num_checks;
	bce_seq_model i_seq (.opcode_valid(opcode_valid), .opcode(opcode), .flag_carry(flag_carry),
		.flag_zero(flag_zero), .flag_sign(flag_sign), .flag_wrap(flag_wrap));
	bce_branch_condition_evaluator i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.opcode_valid(opcode_valid), .opcode(opcode), .flag_carry(flag_carry),
		.flag_zero(flag_zero), .flag_sign(flag_sign), .flag_wrap(flag_wrap),
		.is_short_branch(is_short_branch), .is_absolute_branch(is_absolute_branch),
		.condition_selector(condition_selector), .branch_taken(branch_taken),
		.branch_not_taken(branch_not_taken), .ctl_op(ctl_op), .result_valid(result_valid));
	// 100 ns clock
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Expected condition from flags {carry, zero, sign, wrap}
	function automatic logic cond_of(input logic [3:0] sel, input logic [3:0] f);
		logic c, z, s, v;
		{c, z, s, v} = f;
		case (sel)
			4'h0: return 1'b0;
			4'h1: return s ^ v;
			4'h2: return z | (s ^ v);
			4'h3: return c | z;
			4'h4: return v;
			4'h5: return s;
			4'h6: return z;
			4'h7: return c;
			4'h8: return 1'b1;
			4'h9: return !(s ^ v);
			4'hA: return !(z | (s ^ v));
			4'hB: return !c && !z;
			4'hC: return !v;
			4'hD: return !s;
			4'hE: return !z;
			default: return !c;
		endcase
	endfunction
	// Control column xF from 6 upward maps to codes 1..A in order
	function automatic logic [3:0] ctl_of(input logic [7:0] op);
		return (op[3:0] == 4'hF && op[7:4] >= 4'h6) ? op[7:4] - 4'h5 : 4'h0;
	endfunction
	// Bit compare
	task automatic check1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Nibble compare
	task automatic check4(input logic [3:0] got, input logic [3:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One request, then every output checked one cycle later
	task automatic step(input logic v, input logic [7:0] op, input logic [3:0] f);
		logic sb, ab, t;
		sb = v && op[3:0] == `BCE_LOW_SHORT_BRANCH;
		ab = v && op[3:0] == `BCE_LOW_ABS_BRANCH;
		t = cond_of(op[7:4], f);
		i_seq.present(v, op, f);
		@(negedge ref_clk);
		check1(result_valid, v && !sys_rst);
		check1(is_short_branch, sb && !sys_rst);
		check1(is_absolute_branch, ab && !sys_rst);
		check4(condition_selector, (v && !sys_rst) ? op[7:4] : 4'h0);
		check1(branch_taken, (sb || ab) && t && !sys_rst);
		check1(branch_not_taken, (sb || ab) && !t && !sys_rst);
		check4(ctl_op, (v && !sys_rst) ? ctl_of(op) : 4'h0);
	endtask
	// Verdict
	task automatic results();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial
	begin
		#200000;
		mismatches++;
		results();
	end
	// Test sequence
	initial
	begin
		mismatches = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		i_seq.present(1'b1, 8'h8B, 4'h0);
		repeat (3) @(negedge ref_clk);
		step(1'b1, 8'h8B, 4'h0);
		sys_rst = 1'b0;
		$display("test reset done");
		// Every selector, every flag set, both jump forms, back to back
		for (int k = 0; k < 512; k++)
			step(1'b1, {k[7:4], k[8] ? 4'hD : 4'hB}, k[3:0]);
		$display("test conditions done");
		// Whole control column, then every low nibble under the always selector
		for (int k = 0; k < 16; k++)
			step(1'b1, {k[3:0], 4'hF}, 4'h5);
		for (int k = 0; k < 16; k++)
			step(1'b1, {4'h8, k[3:0]}, 4'hF);
		step(1'b0, 8'h3B, 4'h0);
		$display("test decode done");
		// Reset in mid-run swallows a pending request
		step(1'b1, 8'h6B, 4'h4);
		sys_rst = 1'b1;
		step(1'b1, 8'hDF, 4'h0);
		sys_rst = 1'b0;
		step(1'b1, 8'h0D, 4'hF);
		step(1'b0, 8'h00, 4'h0);
		$display("test midrun reset done");
		results();
	end
endmodule // bce_branch_condition_evaluator_tb

// >>> tb/bce_seq_model.sv
`timescale 1ns/1ps
// Sequencer and flag register driving the evaluator
module bce_seq_model (
	output logic opcode_valid,
	output logic [7:0] opcode,
	output logic flag_carry,
	output logic flag_zero,
	output logic flag_sign,
	output logic flag_wrap
);
	// One fetched byte and current flags; caller sits at a falling edge
	task automatic present(input logic v, input logic [7:0] op, input logic [3:0] f);
		opcode_valid = v;
		// Idle cycles show an inverted byte, never a stale one
		opcode = v ? op : ~op;
		{flag_carry, flag_zero, flag_sign, flag_wrap} = f;
	endtask
endmodule // bce_seq_model
